// ### rtl/fqr_pkg.sv
// Constants and types for the quad read, wrap and reset command block.
package fqr_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_QPI_EXIT = 8'hFF;
  localparam logic [7:0] OP_QPI_ENTER = 8'h38;
  localparam logic [7:0] OP_WORD_RD = 8'hE7;
  localparam logic [7:0] OP_QIO_RD = 8'hEB;
  localparam logic [7:0] OP_FAST_RD = 8'h0B;
  localparam logic [7:0] OP_BURST_RD = 8'h0C;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_SET_PARAM = 8'hC0;
  localparam logic [7:0] OP_RST_ARM = 8'h66;
  localparam logic [7:0] OP_RST_GO = 8'h99;
  // ==========================================================
  // Phase lengths in serial clocks, and the continuous read mode key
  localparam logic [5:0] CMD_CLKS_SPI = 6'h08;
  localparam logic [5:0] CMD_CLKS_QPI = 6'h02;
  localparam logic [5:0] ADDR_CLKS = 6'h06;
  localparam logic [5:0] MODE_CLKS = 6'h02;
  localparam logic [5:0] WORD_DUMMY = 6'h02;
  localparam logic [5:0] DUMMY_SHORT = 6'h04;
  localparam logic [5:0] DUMMY_LONG = 6'h06;
  localparam logic [5:0] WRAP_CLKS_SPI = 6'h20;
  localparam logic [5:0] WRAP_CLKS_QPI = 6'h08;
  localparam logic [5:0] PARAM_CLKS = 6'h02;
  localparam logic [3:0] XIP_KEY = 4'hA;
  // ==========================================================
  // Setting byte fields
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_LEN_POS = 5;
  localparam int DUMMY_SEL_POS = 4;
  localparam int BURST_LEN_POS = 0;
  // ==========================================================
  // Reset recovery time and FIFO size
  localparam int T_RST_US = 30;
  localparam int CLK_MHZ = 40;
  localparam logic [10:0] RST_CYCLES = 11'(T_RST_US * CLK_MHZ);
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_CMD = 3'h1, ST_ADDR = 3'h3, ST_MODE = 3'h2,
    ST_DUMMY = 3'h6, ST_DATA = 3'h7, ST_SETUP = 3'h5, ST_SKIP = 3'h4
  } fqr_state_t;
  typedef struct packed {
    logic four_line_command_mode;
    logic execute_in_place;
    logic wrap_disable_bit;
    logic [1:0] wrap_length_field;
    logic dummy_count_select_bit;
  } fqr_cfg_t;
  localparam fqr_cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b1, 2'h0, 1'b0};
endpackage

// ### rtl/fqr_top.sv
// Serial flash command interpreter for quad reads, wrap setup and soft reset.
//
// Summary of operation
// - FFh in four-line mode returns to SPI
// - E7h accepted only with quad enable set
// - Word read uses two dummy clocks
// - Eight mode bits follow address, high nibble used
// - Mode nibble Ah skips the next opcode
// - Wrapped reads loop inside aligned section
// - 77h: 24 dummy bits then wrap byte
// - 77h accepted only with quad enable set
// - Wrap bit 4 disables, bits 6:5 length
// - Wrap setting governs later E7h and EBh reads
// - 0Ch is a wrapping four-line fast read
// - C0h only accepted in four-line mode
// - Parameter bit 4 picks 4 or 6 dummies
// - Parameter bits 1:0 pick burst length
// - Defaults are wrap off with 8 byte length, 4 dummies
// - Wrap length kept across mode switch
// - Reset needs 66h directly followed by 99h
// - Reset restores power-on volatile state
// - Instructions ignored for 30us after reset
// - 38h enters four-line mode with quad enable
// - Data leaves on falling clock, MSB first
`timescale 1ns/10ps
module fqr_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic rdy_reg, rdy_next, push, pop;
  always_comb
  begin
    push = in_valid_in && rdy_reg;
    pop = out_ready_in && (cnt_reg != '0);
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush_in)
    begin
      wp_next = '0;
      rp_next = '0;
      cnt_next = '0;
    end
    rdy_next = (cnt_next != (AW+1)'(D));
  end
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wp_reg] <= in_data_in;
    end
  end
  assign in_ready_out = rdy_reg;
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out = mem[rp_reg];
endmodule

module fqr_top (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic sclk_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  input wire logic quad_lines_enable_bit_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic rd_ready_out,
  output logic [23:0] fetch_addr_out,
  output logic fetch_en_out,
  output fqr_pkg::fqr_cfg_t cfg_out,
  output logic soft_reset_out,
  output logic reset_busy_out
);
  import fqr_pkg::*;
  // ==========================================================
  // Address step inside an aligned 8 to 64 byte section.
  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap, input logic [1:0] len);
    logic [23:0] mask;
    // The shift is done at full width so that the 64 byte section keeps its top bit.
    mask = (24'h000008 << len) - 24'h000001;
    if (wrap)
      return (a & ~mask) | ((a + 24'h000001) & mask);
    return a + 24'h000001;
  endfunction
  // ==========================================================
  // State
  fqr_state_t st_reg, st_next;
  fqr_cfg_t cfg_reg, cfg_next;
  logic [5:0] cnt_reg, cnt_next, cnt_inc, need;
  logic [31:0] sh_reg, sh_next;
  logic [7:0] op_reg, op_next, byte_in;
  logic [23:0] fa_reg, fa_next;
  logic [10:0] rstc_reg, rstc_next;
  logic [3:0] dout_reg, dout_next, lo_reg, lo_next, oe_reg, oe_next;
  logic sclk_q_reg, arm_reg, arm_next, srst_reg, srst_next, fen_reg, fen_next;
  logic nib_reg, nib_next, wrap_reg, wrap_next, quad, rise, fall, pop, push;
  logic f_valid, f_ready;
  logic busy_reg, busy_next;
  logic [7:0] f_data;
  assign rise = sclk_in && !sclk_q_reg;
  assign fall = !sclk_in && sclk_q_reg;
  assign push = rd_valid_in && fen_reg && f_ready;
  // Address, mode and read data run on four lines even in SPI mode.
  assign quad = cfg_reg.four_line_command_mode || st_reg == ST_ADDR || st_reg == ST_MODE;
  assign cnt_inc = cnt_reg + 6'h01;
  fqr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .flush_in(cs_b_in),
    .in_valid_in(rd_valid_in && fen_reg),
    .in_ready_out(f_ready),
    .in_data_in(rd_data_in),
    .out_valid_out(f_valid),
    .out_ready_in(pop),
    .out_data_out(f_data)
  );
  // ==========================================================
  // Command decoding and phase sequencing
  always_comb
  begin
    st_next = st_reg;
    cfg_next = cfg_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    fa_next = push ? next_addr(fa_reg, wrap_reg, cfg_reg.wrap_length_field) : fa_reg;
    arm_next = arm_reg;
    srst_next = 1'b0;
    rstc_next = (rstc_reg != 11'h000) ? rstc_reg - 11'h001 : rstc_reg;
    fen_next = fen_reg;
    wrap_next = wrap_reg;
    dout_next = dout_reg;
    lo_next = lo_reg;
    oe_next = oe_reg;
    nib_next = nib_reg;
    pop = 1'b0;
    sh_next = quad ? {sh_reg[27:0], io_in} : {sh_reg[30:0], io_in[0]};
    byte_in = sh_next[7:0];
    if (op_reg == OP_WORD_RD)
      need = WORD_DUMMY;
    else if (op_reg == OP_QIO_RD && !cfg_reg.four_line_command_mode)
      need = DUMMY_SHORT;
    else
      need = cfg_reg.dummy_count_select_bit ? DUMMY_LONG : DUMMY_SHORT;
    if (!rise)
      sh_next = sh_reg;
    if (cs_b_in)
    begin
      st_next = ST_IDLE;
      oe_next = 4'h0;
      fen_next = 1'b0;
    end
    else if (st_reg == ST_IDLE)
    begin
      cnt_next = 6'h00;
      nib_next = 1'b0;
      if (rstc_reg != 11'h000)
        st_next = ST_SKIP;
      else if (cfg_reg.execute_in_place)
        st_next = ST_ADDR;
      else
        st_next = ST_CMD;
    end
    else if (rise)
    begin
      cnt_next = cnt_inc;
      case (st_reg)
        ST_CMD:
        begin
          if (cnt_inc == (cfg_reg.four_line_command_mode ? CMD_CLKS_QPI : CMD_CLKS_SPI))
          begin
            cnt_next = 6'h00;
            op_next = byte_in;
            st_next = ST_SKIP;
            arm_next = (byte_in == OP_RST_ARM);
            if (byte_in == OP_RST_GO && arm_reg)
            begin
              srst_next = 1'b1;
              cfg_next = CFG_RESET;
              rstc_next = RST_CYCLES;
            end
            else if (byte_in == OP_QPI_EXIT && cfg_reg.four_line_command_mode)
              cfg_next.four_line_command_mode = 1'b0;
            else if (byte_in == OP_QPI_ENTER && quad_lines_enable_bit_in)
              cfg_next.four_line_command_mode = 1'b1;
            else if ((byte_in == OP_WORD_RD || byte_in == OP_QIO_RD) && quad_lines_enable_bit_in)
              st_next = ST_ADDR;
            else if ((byte_in == OP_FAST_RD || byte_in == OP_BURST_RD) && cfg_reg.four_line_command_mode)
              st_next = ST_ADDR;
            else if (byte_in == OP_SET_WRAP && quad_lines_enable_bit_in)
              st_next = ST_SETUP;
            else if (byte_in == OP_SET_PARAM && cfg_reg.four_line_command_mode)
              st_next = ST_SETUP;
          end
        end
        ST_ADDR:
        begin
          if (cnt_inc == ADDR_CLKS)
          begin
            cnt_next = 6'h00;
            fa_next = sh_next[23:0];
            fen_next = 1'b1;
            st_next = (op_reg == OP_FAST_RD || op_reg == OP_BURST_RD) ? ST_DUMMY : ST_MODE;
            wrap_next = (op_reg == OP_BURST_RD) || (op_reg != OP_FAST_RD && !cfg_reg.wrap_disable_bit);
          end
        end
        ST_MODE:
        begin
          if (cnt_inc == MODE_CLKS)
          begin
            cnt_next = 6'h00;
            st_next = ST_DUMMY;
            cfg_next.execute_in_place = (sh_next[7:4] == XIP_KEY);
          end
        end
        ST_DUMMY:
        begin
          if (cnt_inc == need)
            st_next = ST_DATA;
        end
        ST_SETUP:
        begin
          if (op_reg == OP_SET_WRAP)
          begin
            if (cnt_inc == (cfg_reg.four_line_command_mode ? WRAP_CLKS_QPI : WRAP_CLKS_SPI))
            begin
              st_next = ST_SKIP;
              cfg_next.wrap_disable_bit = byte_in[WRAP_DIS_POS];
              cfg_next.wrap_length_field = byte_in[WRAP_LEN_POS +: 2];
            end
          end
          else if (cnt_inc == PARAM_CLKS)
          begin
            st_next = ST_SKIP;
            cfg_next.dummy_count_select_bit = byte_in[DUMMY_SEL_POS];
            cfg_next.wrap_length_field = byte_in[BURST_LEN_POS +: 2];
          end
        end
        default:
        begin
          cnt_next = cnt_reg;
        end
      endcase
    end
    else if (fall && st_reg == ST_DATA)
    begin
      // The host must have let go of the lines before this edge.
      oe_next = 4'hF;
      nib_next = !nib_reg;
      if (!nib_reg)
      begin
        pop = f_valid;
        // An underrun sends ones rather than stalling the serial clock.
        dout_next = f_valid ? f_data[7:4] : 4'hF;
        lo_next = f_valid ? f_data[3:0] : 4'hF;
      end
      else
        dout_next = lo_reg;
    end
    busy_next = (rstc_next != 11'h000);
  end
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st_reg <= ST_IDLE;
      cfg_reg <= CFG_RESET;
      cnt_reg <= 6'h00;
      sh_reg <= 32'h00000000;
      op_reg <= 8'h00;
      fa_reg <= 24'h000000;
      arm_reg <= 1'b0;
      srst_reg <= 1'b0;
      rstc_reg <= 11'h000;
      busy_reg <= 1'b0;
      fen_reg <= 1'b0;
      wrap_reg <= 1'b0;
      dout_reg <= 4'h0;
      lo_reg <= 4'h0;
      oe_reg <= 4'h0;
      nib_reg <= 1'b0;
      sclk_q_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cfg_reg <= cfg_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      op_reg <= op_next;
      fa_reg <= fa_next;
      arm_reg <= arm_next;
      srst_reg <= srst_next;
      rstc_reg <= rstc_next;
      busy_reg <= busy_next;
      fen_reg <= fen_next;
      wrap_reg <= wrap_next;
      dout_reg <= dout_next;
      lo_reg <= lo_next;
      oe_reg <= oe_next;
      nib_reg <= nib_next;
      sclk_q_reg <= sclk_in;
    end
  end
  assign io_out = dout_reg;
  assign io_oe_out = oe_reg;
  assign rd_ready_out = f_ready;
  assign fetch_addr_out = fa_reg;
  assign fetch_en_out = fen_reg;
  assign cfg_out = cfg_reg;
  assign soft_reset_out = srst_reg;
  assign reset_busy_out = busy_reg;
  // ==========================================================
  // Checks
  sequence seq_cmd_done;
    st_reg == ST_CMD && st_next != ST_CMD && !cs_b_in;
  endsequence
  sequence seq_rst_go;
    seq_cmd_done ##0 (byte_in == OP_RST_GO) && arm_reg;
  endsequence
  chk_qpi_exit: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $fell(cfg_reg.four_line_command_mode) |-> $past(byte_in == OP_QPI_EXIT || srst_next))
    else $error("four-line mode left without exit opcode");
  chk_qpi_enter: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $rose(cfg_reg.four_line_command_mode) |-> $past(quad_lines_enable_bit_in && byte_in == OP_QPI_ENTER))
    else $error("four-line mode entered illegally");
  chk_word_qe: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    seq_cmd_done ##0 byte_in == OP_WORD_RD && !quad_lines_enable_bit_in |=> st_reg == ST_SKIP)
    else $error("word read accepted without quad enable");
  chk_reset_pair: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $rose(soft_reset_out) |-> $past(arm_reg, 2))
    else $error("reset without armed state");
  chk_reset_state: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    seq_rst_go |=> cfg_reg == CFG_RESET ##0 soft_reset_out ##1 !soft_reset_out)
    else $error("reset did not restore defaults");
  chk_reset_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    reset_busy_out && st_reg == ST_IDLE && !cs_b_in |=> st_reg == ST_SKIP)
    else $error("instruction taken during reset recovery");
  chk_dummy_count: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    st_reg == ST_DUMMY && st_next == ST_DATA && op_reg == OP_WORD_RD |-> cnt_reg == 6'h01)
    else $error("word read dummy count wrong");
  chk_xip_skip: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    st_reg == ST_IDLE && !cs_b_in && cfg_reg.execute_in_place && !reset_busy_out |=> st_reg == ST_ADDR)
    else $error("continuous read did not skip opcode");
  chk_data_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $rose(io_oe_out[0]) |-> st_reg == ST_DATA && $past(fall) && nib_reg)
    else $error("output enabled off a falling edge");
endmodule

// ### testbench/fqr_host.sv
// Host controller model that drives chip select, serial clock and IO lines.
`timescale 1ns/10ps
module fqr_host (
  input wire logic ref_clk_in,
  input wire logic [3:0] dev_io_in,
  input wire logic [3:0] dev_oe_in,
  output logic cs_b_out,
  output logic sclk_out,
  output logic [3:0] line_out
);
  logic [3:0] drv;
  logic en;
  logic [3:0] last;
  initial
  begin
    cs_b_out = 1'b1;
    sclk_out = 1'b0;
    drv = 4'h0;
    en = 1'b0;
    last = 4'h0;
  end
  // A released line shows the inverse of its last value, so a stale nibble never reads as valid.
  assign line_out = (dev_oe_in & dev_io_in) | (~dev_oe_in & (en ? drv : ~last));
  always @(posedge ref_clk_in)
  begin
    if (en)
      last <= drv;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask
  // The serial clock idles low and each level lasts three system clocks.
  task automatic clk(input logic [3:0] nib, input logic drive, output logic [3:0] got);
    drv = nib;
    en = drive;
    wt(3);
    got = line_out;
    sclk_out = 1'b1;
    wt(3);
    sclk_out = 1'b0;
  endtask
  task automatic send(input logic [31:0] v, input int n, input logic q);
    logic [3:0] g;
    for (int i = n - 1; i >= 0; i--)
      clk(q ? v[4*i+:4] : {3'h0, v[i]}, 1'b1, g);
  endtask
  task automatic start();
    cs_b_out = 1'b0;
    wt(2);
  endtask
  task automatic stop();
    en = 1'b0;
    cs_b_out = 1'b1;
    wt(4);
  endtask
endmodule

// ### testbench/flash_quad_read_wrap_reset_bench.sv
// Self-checking bench for the quad read, wrap and soft reset command block.
`timescale 1ns/10ps
module flash_quad_read_wrap_reset_bench;
  import fqr_pkg::*;
  logic ref_clk_in, rst_b_in, qe, rd_valid, cs_b, sclk, rd_ready, fetch_en, soft_rst, busy;
  logic [3:0] line, io_out, io_oe;
  logic [23:0] fetch_addr, sa;
  fqr_cfg_t cfg;
  logic em, ex, ew, ed;
  logic [1:0] el;
  logic [7:0] wb;
  int errors, n_compared, n_pulse, nb, nb0;
  fqr_top dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b), .sclk_in(sclk), .io_in(line),
    .io_out(io_out), .io_oe_out(io_oe), .quad_lines_enable_bit_in(qe), .rd_data_in(fetch_addr[7:0] ^ 8'hA5),
    .rd_valid_in(rd_valid), .rd_ready_out(rd_ready), .fetch_addr_out(fetch_addr), .fetch_en_out(fetch_en),
    .cfg_out(cfg), .soft_reset_out(soft_rst), .reset_busy_out(busy));
  fqr_host host (.ref_clk_in(ref_clk_in), .dev_io_in(io_out), .dev_oe_in(io_oe), .cs_b_out(cs_b),
    .sclk_out(sclk), .line_out(line));
  // ==========================================================
  // Clock, array model and counters
  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  // The array stalls at random; the FIFO still runs full, as the host drains a byte only every 12 system clocks.
  always @(posedge ref_clk_in)
  begin
    #2;
    rd_valid = ($urandom % 4) != 0;
    n_pulse += (soft_rst === 1'b1);
    nb += (busy === 1'b1);
  end
  // ==========================================================
  // Checks and expectations
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ccfg();
    chk("config", 32'({em, ex, ew, el, ed}), 32'(cfg));
  endtask
  function automatic logic [7:0] exp_byte(input logic [23:0] s, input int k, input logic w, input logic [1:0] len);
    logic [23:0] m;
    logic [23:0] a;
    m = (24'h8 << len) - 24'h1;
    a = w ? ((s & ~m) | ((s + 24'(k)) & m)) : s + 24'(k);
    return a[7:0] ^ 8'hA5;
  endfunction
  task automatic cmd(input logic [7:0] op, input logic q, input logic [31:0] x, input int xn);
    host.start();
    host.send({24'h0, op}, q ? 2 : 8, q);
    if (xn > 0)
      host.send(x, xn, q);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] op, input logic q, input logic skip, input logic md, input logic [7:0] mode,
    input int dum, input logic [23:0] s, input int n, input logic w);
    logic [3:0] hi, lo;
    host.start();
    if (!skip)
      host.send({24'h0, op}, q ? 2 : 8, q);
    host.send({8'h0, s}, 6, 1'b1);
    if (md)
      host.send({24'h0, mode}, 2, 1'b1);
    repeat (dum) host.clk(4'h0, 1'b0, hi);
    chk("fetch enable", 32'h1, 32'(fetch_en));
    for (int k = 0; k < n; k++)
    begin
      host.clk(4'h0, 1'b0, hi);
      host.clk(4'h0, 1'b0, lo);
      chk("read byte", 32'(exp_byte(s, k, w, el)), 32'({hi, lo}));
    end
    host.stop();
    chk("fifo ready", 32'h1, 32'(rd_ready));
  endtask
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #(60000 * 25);
    errors++;
    summarize();
  end
  // ==========================================================
  // Scenarios
  initial
  begin
    rst_b_in = 1'b0;
    qe = 1'b0;
    {em, ex, ew, el, ed} = 6'h08;
    void'($urandom(91123));
    repeat (5) @(posedge ref_clk_in);
    #2 rst_b_in = 1'b1;
    host.wt(2);
    ccfg();
    cmd(OP_QPI_ENTER, 1'b0, 32'h0, 0);
    ccfg();
    cmd(OP_SET_WRAP, 1'b0, 32'h00000000, 32);
    ccfg();
    host.start();
    host.send({24'h0, OP_WORD_RD}, 8, 1'b0);
    host.send(32'h000100, 6, 1'b1);
    chk("fetch enable", 32'h0, 32'(fetch_en));
    host.stop();
    qe = 1'b1;
    cmd(OP_SET_PARAM, 1'b0, 32'h13, 8);
    ccfg();
    for (int i = 0; i < 4; i++)
    begin
      wb = {1'($urandom), 2'(i), 1'b0, 4'($urandom)};
      cmd(OP_SET_WRAP, 1'b0, {24'($urandom), wb}, 32);
      ew = 1'b0;
      el = 2'(i);
      ccfg();
      sa = 24'($urandom) & 24'hFFFFFE;
      rd(OP_WORD_RD, 1'b0, 1'b0, 1'b1, 8'h05, 2, sa, (8 << i) + 2, 1'b1);
    end
    cmd(OP_SET_WRAP, 1'b0, 32'h00000070, 32);
    ew = 1'b1;
    ccfg();
    rd(OP_WORD_RD, 1'b0, 1'b0, 1'b1, 8'hA5, 2, 24'h00003E, 4, 1'b0);
    ex = 1'b1;
    ccfg();
    rd(OP_WORD_RD, 1'b0, 1'b1, 1'b1, 8'h3A, 2, 24'h0001FA, 3, 1'b0);
    ex = 1'b0;
    ccfg();
    rd(OP_WORD_RD, 1'b0, 1'b0, 1'b1, 8'h00, 2, 24'h000200, 2, 1'b0);
    cmd(OP_QPI_ENTER, 1'b0, 32'h0, 0);
    em = 1'b1;
    ccfg();
    cmd(OP_SET_PARAM, 1'b1, {24'h0, 3'($urandom), 1'b1, 2'($urandom), 2'h1}, 2);
    ed = 1'b1;
    el = 2'h1;
    ccfg();
    rd(OP_BURST_RD, 1'b1, 1'b0, 1'b0, 8'h00, 6, 24'h00107A, 18, 1'b1);
    rd(OP_FAST_RD, 1'b1, 1'b0, 1'b0, 8'h00, 6, 24'h00107A, 5, 1'b0);
    rd(OP_QIO_RD, 1'b1, 1'b0, 1'b1, 8'h00, 6, 24'h0020F1, 5, 1'b0);
    cmd(OP_QPI_EXIT, 1'b1, 32'h0, 0);
    em = 1'b0;
    ccfg();
    cmd(OP_RST_ARM, 1'b0, 32'h0, 0);
    cmd(OP_QPI_ENTER, 1'b0, 32'h0, 0);
    cmd(OP_RST_GO, 1'b1, 32'h0, 0);
    em = 1'b1;
    ccfg();
    chk("reset pulses", 32'h0, 32'(n_pulse));
    nb0 = nb;
    cmd(OP_RST_ARM, 1'b1, 32'h0, 0);
    cmd(OP_RST_GO, 1'b1, 32'h0, 0);
    {em, ex, ew, el, ed} = 6'h08;
    chk("reset pulses", 32'h1, 32'(n_pulse));
    ccfg();
    cmd(OP_QPI_ENTER, 1'b0, 32'h0, 0);
    ccfg();
    for (int t = 0; t < 1400 && busy !== 1'b0; t++)
      host.wt(1);
    chk("busy length", 32'(RST_CYCLES), 32'(nb - nb0));
    cmd(OP_QPI_ENTER, 1'b0, 32'h0, 0);
    em = 1'b1;
    ccfg();
    summarize();
  end
endmodule
